/* common/int_ctrl_defs.vh */
`ifndef INT_CTRL_DEFS_VH
`define INT_CTRL_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_MAIN          5'h00
`define ADDR_EDGE_PRIO     5'h04
`define ADDR_EXT_LINES     5'h08
`define ADDR_RESET_CTRL    5'h0C
`define ADDR_VECTOR        5'h10

// ----------------------------------------------------------------
// main register fields
// ----------------------------------------------------------------
`define MAIN_GLOBAL_GATE   7
`define MAIN_PERIPH_GATE   6
`define MAIN_TIMER_ZERO_EN       5
`define MAIN_EXT0_EN       4
`define MAIN_PORT_EN       3
`define MAIN_TIMER_ZERO_FLAG     2
`define MAIN_EXT0_FLAG     1
`define MAIN_PORT_FLAG     0

// ----------------------------------------------------------------
// edge/priority register fields
// ----------------------------------------------------------------
`define EP_PULLUP_DIS      7
`define EP_EXT0_EDGE       6
`define EP_EXT1_EDGE       5
`define EP_EXT2_EDGE       4
`define EP_TIMER_ZERO_PRIO       2
`define EP_PORT_PRIO       0
`define EP_IMPL_MASK       8'hF5

// ----------------------------------------------------------------
// external-lines register fields
// ----------------------------------------------------------------
`define XL_EXT2_PRIO       7
`define XL_EXT1_PRIO       6
`define XL_EXT2_EN         4
`define XL_EXT1_EN         3
`define XL_EXT2_FLAG       1
`define XL_EXT1_FLAG       0
`define XL_IMPL_MASK       8'hDB

// ----------------------------------------------------------------
// reset-control register and reset values
// ----------------------------------------------------------------
`define RC_PRIO_MODE       7
`define RC_IMPL_MASK       8'h80
`define MAIN_RESET         8'h00
`define EP_RESET           8'hF5
`define XL_RESET           8'hC0
`define RC_RESET           8'h00

// ----------------------------------------------------------------
// vector addresses
// ----------------------------------------------------------------
`define VEC_HIGH           24'h000008
`define VEC_LOW            24'h000018

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* hw/int_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_defs.vh"

module int_ctrl (
	// clock and reset
	input  wire        CLOCK,
	input  wire        RST,
	// axi4-lite write address
	input  wire [4:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	// axi4-lite write data
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	// axi4-lite write response
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	// axi4-lite read address
	input  wire [4:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	// axi4-lite read data
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	// event sources
	input  wire        TIMER_ZERO_OVERFLOW,
	input  wire [2:0]  EXT_LINE,
	input  wire [3:0]  UPPER_PORT_PINS,
	input  wire        PERIPH_REQ,
	input  wire        PERIPH_PRIORITY,
	input  wire [3:0]  PORT_PULLUP_LATCH,
	output reg  [3:0]  PORT_PULLUP_ON,
	// core vector handshake
	output reg         IRQ_VALID,
	output reg  [23:0] IRQ_VECTOR,
	input  wire        IRQ_ACCEPT,
	output reg  [4:0]  PENDING
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg  [7:0] main_reg;
	reg  [7:0] edge_prio_reg;
	reg  [7:0] ext_lines_reg;
	reg  [7:0] reset_ctrl_reg;
	reg  [2:0] ext_line_prev_reg;
	reg  [3:0] port_snap_reg;
	reg        aw_got_reg;
	reg        w_got_reg;
	reg  [4:0] aw_addr_reg;
	reg  [7:0] w_data_reg;
	reg        w_lane_reg;

	wire       prio_mode   = reset_ctrl_reg[`RC_PRIO_MODE];
	wire       gate_global = main_reg[`MAIN_GLOBAL_GATE];
	wire       gate_periph = main_reg[`MAIN_PERIPH_GATE];

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	wire [2:0] edge_sel = {edge_prio_reg[`EP_EXT2_EDGE], edge_prio_reg[`EP_EXT1_EDGE],
		edge_prio_reg[`EP_EXT0_EDGE]};
	wire [2:0] ext_event;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
			assign ext_event[gi] = edge_sel[gi] ? (EXT_LINE[gi] & ~ext_line_prev_reg[gi])
				: (~EXT_LINE[gi] & ext_line_prev_reg[gi]);
		end
	endgenerate
	wire       port_mismatch = |(UPPER_PORT_PINS ^ port_snap_reg);

	// hardware set requests, one per flag
	wire       set_timer_zero = TIMER_ZERO_OVERFLOW;
	wire       set_ext0 = ext_event[0];
	wire       set_ext1 = ext_event[1];
	wire       set_ext2 = ext_event[2];
	wire       set_port = port_mismatch;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire       wr_fire   = aw_got_reg && w_got_reg && !S_AXI_BVALID;
	// a clear byte-lane strobe still gets its answer but writes nothing
	wire       wr_ok     = wr_fire && w_lane_reg;
	wire       aw_main   = aw_addr_reg == `ADDR_MAIN;
	wire       aw_ep     = aw_addr_reg == `ADDR_EDGE_PRIO;
	wire       aw_xl     = aw_addr_reg == `ADDR_EXT_LINES;
	wire       aw_rc     = aw_addr_reg == `ADDR_RESET_CTRL;
	wire       wr_main   = wr_ok && aw_main;
	wire       wr_ep     = wr_ok && aw_ep;
	wire       wr_xl     = wr_ok && aw_xl;
	wire       wr_rc     = wr_ok && aw_rc;
	wire       wr_known  = aw_main || aw_ep || aw_xl || aw_rc;
	wire       rd_fire   = S_AXI_ARVALID && !S_AXI_RVALID;
	// the status read doubles as the port read that ends a mismatch
	wire       rd_status = rd_fire && S_AXI_ARADDR == `ADDR_VECTOR;

	assign S_AXI_AWREADY = !aw_got_reg;
	assign S_AXI_WREADY  = !w_got_reg;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	// ----------------------------------------------------------------
	// request qualification
	// ----------------------------------------------------------------
	// per-source flag fields
	wire       flag_port = main_reg[`MAIN_PORT_FLAG];
	wire       flag_ext0 = main_reg[`MAIN_EXT0_FLAG];
	wire       flag_timer_zero = main_reg[`MAIN_TIMER_ZERO_FLAG];
	wire       flag_ext1 = ext_lines_reg[`XL_EXT1_FLAG];
	wire       flag_ext2 = ext_lines_reg[`XL_EXT2_FLAG];

	// per-source enable fields
	wire       en_port   = main_reg[`MAIN_PORT_EN];
	wire       en_ext0   = main_reg[`MAIN_EXT0_EN];
	wire       en_timer_zero   = main_reg[`MAIN_TIMER_ZERO_EN];
	wire       en_ext1   = ext_lines_reg[`XL_EXT1_EN];
	wire       en_ext2   = ext_lines_reg[`XL_EXT2_EN];

	// per-source priority fields
	wire       prio_port = edge_prio_reg[`EP_PORT_PRIO];
	wire       prio_timer_zero = edge_prio_reg[`EP_TIMER_ZERO_PRIO];
	wire       prio_ext1 = ext_lines_reg[`XL_EXT1_PRIO];
	wire       prio_ext2 = ext_lines_reg[`XL_EXT2_PRIO];
	// line zero has no priority bit and always ranks high
	wire       prio_ext0 = 1'b1;

	// bit order: 0 port, 1 ext0, 2 timer, 3 ext1, 4 ext2; peripheral separate
	wire [4:0] src_flag  = {flag_ext2, flag_ext1, flag_timer_zero, flag_ext0, flag_port};
	wire [4:0] src_en    = {en_ext2, en_ext1, en_timer_zero, en_ext0, en_port};
	wire [4:0] src_req   = src_flag & src_en;
	wire [4:0] src_prio  = {prio_ext2, prio_ext1, prio_timer_zero, prio_ext0, prio_port};
	wire [4:0] hi_req    = src_req & src_prio;
	wire [4:0] lo_req    = src_req & ~src_prio;
	wire       periph_hi = PERIPH_REQ && PERIPH_PRIORITY;
	wire       periph_lo = PERIPH_REQ && !PERIPH_PRIORITY;
	reg        want_high;
	reg        want_low;

	always @* begin
		PENDING   = 5'h00;
		want_high = 1'b0;
		want_low  = 1'b0;
		if (!prio_mode) begin
			// every source ranks high behind the global gate; the peripheral also needs its own gate
			PENDING   = src_req & {5{gate_global}};
			want_high = (|PENDING) || (PERIPH_REQ && gate_global && gate_periph);
		end else begin
			PENDING   = (hi_req & {5{gate_global}}) | (lo_req & {5{gate_periph}});
			want_high = ((|hi_req) && gate_global) || (periph_hi && gate_global);
			want_low  = ((|lo_req) && gate_periph) || (periph_lo && gate_periph);
		end
	end

	// ----------------------------------------------------------------
	// vector output
	// ----------------------------------------------------------------
	// high wins when both levels ask; compatibility mode never asks low
	wire        offer_next  = want_high || want_low;
	wire [23:0] vector_next = want_high ? `VEC_HIGH : `VEC_LOW;

	always @(posedge CLOCK) begin
		if (RST) begin
			IRQ_VALID  <= 1'b0;
			IRQ_VECTOR <= 24'h000000;
		end else if (IRQ_VALID && IRQ_ACCEPT) begin
			IRQ_VALID  <= 1'b0;
		end else begin
			IRQ_VALID  <= offer_next;
			IRQ_VECTOR <= vector_next;
		end
	end

	wire take_high = IRQ_VALID && IRQ_ACCEPT && IRQ_VECTOR == `VEC_HIGH;
	wire take_low  = IRQ_VALID && IRQ_ACCEPT && IRQ_VECTOR == `VEC_LOW;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always @(posedge CLOCK) begin
		if (RST) begin
			main_reg          <= `MAIN_RESET;
			edge_prio_reg     <= `EP_RESET;
			ext_lines_reg     <= `XL_RESET;
			reset_ctrl_reg    <= `RC_RESET;
			// start from the pin level so a high idle line gives no false edge
			ext_line_prev_reg <= EXT_LINE;
			port_snap_reg     <= 4'h0;
		end else begin
			ext_line_prev_reg <= EXT_LINE;
			// software writes first, so the hardware updates below win
			if (wr_main) begin
				main_reg <= w_data_reg;
			end
			if (wr_ep) begin
				edge_prio_reg <= w_data_reg & `EP_IMPL_MASK;
			end
			if (wr_xl) begin
				ext_lines_reg <= w_data_reg & `XL_IMPL_MASK;
			end
			if (wr_rc) begin
				reset_ctrl_reg <= w_data_reg & `RC_IMPL_MASK;
			end
			// a read of the status word ends the port mismatch
			if (rd_status) begin
				port_snap_reg <= UPPER_PORT_PINS;
			end
			// taking an interrupt closes the gate that let it through
			if (take_high) begin
				main_reg[`MAIN_GLOBAL_GATE] <= 1'b0;
			end
			if (take_low) begin
				main_reg[`MAIN_PERIPH_GATE] <= 1'b0;
			end
			// flag sets come last and beat a same-cycle clear
			if (set_timer_zero) begin
				main_reg[`MAIN_TIMER_ZERO_FLAG] <= 1'b1;
			end
			if (set_ext0) begin
				main_reg[`MAIN_EXT0_FLAG] <= 1'b1;
			end
			if (set_port) begin
				main_reg[`MAIN_PORT_FLAG] <= 1'b1;
			end
			if (set_ext1) begin
				ext_lines_reg[`XL_EXT1_FLAG] <= 1'b1;
			end
			if (set_ext2) begin
				ext_lines_reg[`XL_EXT2_FLAG] <= 1'b1;
			end
		end
	end

	always @* begin
		PORT_PULLUP_ON = edge_prio_reg[`EP_PULLUP_DIS] ? 4'h0 : PORT_PULLUP_LATCH;
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	always @(posedge CLOCK) begin
		if (RST) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			aw_addr_reg  <= 5'h00;
			w_data_reg   <= 8'h00;
			w_lane_reg   <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && !aw_got_reg) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_got_reg) begin
				w_got_reg  <= 1'b1;
				w_data_reg <= S_AXI_WDATA[7:0];
				w_lane_reg <= S_AXI_WSTRB[0];
			end
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	reg  [31:0] rd_word;
	reg  [1:0]  rd_resp;

	// read mux: unmapped words answer an error and read zero
	always @* begin
		rd_word = 32'h00000000;
		rd_resp = `RESP_OKAY;
		case (S_AXI_ARADDR)
		`ADDR_MAIN: begin
			rd_word = {24'h000000, main_reg};
		end
		`ADDR_EDGE_PRIO: begin
			rd_word = {24'h000000, edge_prio_reg};
		end
		`ADDR_EXT_LINES: begin
			rd_word = {24'h000000, ext_lines_reg};
		end
		`ADDR_RESET_CTRL: begin
			rd_word = {24'h000000, reset_ctrl_reg};
		end
		`ADDR_VECTOR: begin
			rd_word = {4'h0, UPPER_PORT_PINS, IRQ_VECTOR};
		end
		default: begin
			rd_resp = `RESP_SLVERR;
		end
		endcase
	end

	always @(posedge CLOCK) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= `RESP_OKAY;
		end else if (rd_fire) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_word;
			S_AXI_RRESP  <= rd_resp;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule // int_ctrl

`default_nettype wire

/* tb/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// offer from the block
	input  wire logic        irq_v,
	input  wire logic [23:0] irq_vec,
	input  wire logic [3:0]  lag,
	// acceptance and vector taken
	output var  logic        irq_acc,
	output var  logic        tk,
	output var  logic [23:0] tk_vec
);
	logic [3:0] wait_reg;
	// a busy core holds off acceptance by lag cycles
	always @(posedge clk) begin
		tk <= irq_v && irq_acc;
		tk_vec <= irq_vec;
		if (rst || !irq_v || irq_acc) begin
			irq_acc <= 1'h0;
			wait_reg <= 4'h0;
		end else if (wait_reg == lag)
			irq_acc <= 1'h1;
		else
			wait_reg <= wait_reg + 4'h1;
	end
endmodule // core_model
`default_nettype wire

/* tb/int_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_defs.vh"
module int_ctrl_assertions (
	// clock and reset
	input wire logic        CLOCK,
	input wire logic        RST,
	// register bus
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	// pull-ups and core link
	input wire logic [3:0]  PORT_PULLUP_LATCH,
	input wire logic [3:0]  PORT_PULLUP_ON,
	input wire logic        IRQ_VALID,
	input wire logic [23:0] IRQ_VECTOR,
	input wire logic        IRQ_ACCEPT,
	input wire logic        PERIPH_REQ,
	input wire logic [4:0]  PENDING
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	property p_pull; PORT_PULLUP_ON == 4'h0 || PORT_PULLUP_ON == PORT_PULLUP_LATCH; endproperty
	a_pull: assert property (p_pull) else $error("pull-up output wrong");
	property p_vec; IRQ_VALID |-> IRQ_VECTOR == `VEC_HIGH || IRQ_VECTOR == `VEC_LOW; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_take; IRQ_VALID && IRQ_ACCEPT |=> !IRQ_VALID; endproperty
	a_take: assert property (p_take) else $error("offer kept after accept");
	property p_rise; $rose(IRQ_VALID) |-> $past(PENDING) != 5'h00 || $past(PERIPH_REQ); endproperty
	a_rise: assert property (p_rise) else $error("offer without request");
	property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_arrdy; S_AXI_ARREADY == !S_AXI_RVALID; endproperty
	a_arrdy: assert property (p_arrdy) else $error("read ready wrong");
	property p_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
endmodule // int_ctrl_assertions
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_defs.vh"
module testbench;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, tmr, preq;
	logic [3:0]  wstrb;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [2:0]  ext;
	logic [3:0]  pins, latch, lag;
	wire         awready, wready, bvalid, arready, rvalid, irq_v, irq_acc, tk;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [23:0] irq_vec, tk_vec;
	wire  [3:0]  pull;
	wire  [4:0]  pend;
	logic [33:0] rq[$];
	logic [23:0] vq[$];
	logic [1:0]  bq[$];
	int          n_mismatch, comparisons, seed;
	int_ctrl int_ctrl_i (.CLOCK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .TIMER_ZERO_OVERFLOW(tmr), .EXT_LINE(ext),
		.UPPER_PORT_PINS(pins), .PERIPH_REQ(preq), .PERIPH_PRIORITY(1'h0),
		.PORT_PULLUP_LATCH(latch), .PORT_PULLUP_ON(pull), .IRQ_VALID(irq_v),
		.IRQ_VECTOR(irq_vec), .IRQ_ACCEPT(irq_acc), .PENDING(pend));
	core_model core_model_i (.clk(clk), .rst(rst), .irq_v(irq_v), .irq_vec(irq_vec),
		.lag(lag), .irq_acc(irq_acc), .tk(tk), .tk_vec(tk_vec));
	task chk(input string s, input [33:0] e, input [33:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 40) begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	task wr(input [4:0] a, input [7:0] d, input [1:0] r = 2'h0);
		int n;
		bq.push_back(r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 40 && !(bvalid && bready); n++) begin
			@(posedge clk);
			if (awready && awvalid)
				awvalid <= 1'h0;
			if (wready && wvalid)
				wvalid <= 1'h0;
		end
		bready <= 1'h0;
		tmo(n);
	endtask
	task rd(input [4:0] a, input [31:0] d, input [1:0] r = 2'h0);
		int n;
		rq.push_back({r, d});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 40 && !(rvalid && rready); n++) begin
			@(posedge clk);
			if (arready && arvalid)
				arvalid <= 1'h0;
		end
		rready <= 1'h0;
		tmo(n);
	endtask
	task pulse;
		@(posedge clk);
		tmr <= 1'h1;
		@(posedge clk);
		tmr <= 1'h0;
	endtask
	task take(input [23:0] v);
		int n;
		vq.push_back(v);
		pulse;
		for (n = 0; n < 40 && vq.size() > 0; n++)
			@(posedge clk);
		tmo(n);
	endtask
	// results are compared against the oldest note as they appear
	always @(posedge clk) begin
		if (rvalid && rready)
			chk("read", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready)
			chk("bresp", bq.pop_front(), bresp);
		if (tk)
			chk("vector", vq.pop_front(), tk_vec);
	end
	always @(posedge clk)
		latch <= 4'($random(seed));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		seed = 32'hDF1754BF;
		{rst, awvalid, wvalid, bready, arvalid, rready, tmr, preq} = 8'h80;
		{awaddr, araddr, wdata, ext, pins, lag} = '0;
		wstrb = 4'hF;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(5'h00, 32'h00);
		rd(5'h04, 32'hF5);
		rd(5'h08, 32'hC0);
		rd(5'h0C, 32'h00);
		#1 chk("pull", 4'h0, pull);
		wr(5'h04, 8'hFF);
		rd(5'h04, 32'hF5);
		wr(5'h08, 8'hFF);
		rd(5'h08, 32'hDB);
		wr(5'h08, 8'h00);
		wstrb <= 4'h0;
		wr(5'h08, 8'hFF);
		wstrb <= 4'hF;
		rd(5'h08, 32'h00);
		wr(5'h14, 8'hFF, 2'h2);
		rd(5'h14, 32'h00, 2'h2);
		$display("test registers finished");
		ext <= 3'h7;
		pulse;
		rd(5'h00, 32'h06);
		rd(5'h08, 32'h03);
		wr(5'h04, 8'h00);
		#1 chk("pull", latch, pull);
		wr(5'h00, 8'h00);
		wr(5'h08, 8'h00);
		ext <= 3'h0;
		repeat (3) @(posedge clk);
		rd(5'h00, 32'h02);
		rd(5'h08, 32'h03);
		wr(5'h00, 8'h00);
		wr(5'h08, 8'h00);
		ext <= 3'h7;
		repeat (3) @(posedge clk);
		rd(5'h00, 32'h00);
		rd(5'h08, 32'h00);
		pins <= 4'hA;
		repeat (2) @(posedge clk);
		rd(5'h00, 32'h01);
		wr(5'h00, 8'h00);
		rd(5'h00, 32'h01);
		rd(5'h10, 32'h0A000018);
		wr(5'h00, 8'h00);
		rd(5'h00, 32'h00);
		$display("test flags finished");
		wr(5'h00, 8'hA0);
		take(`VEC_HIGH);
		rd(5'h00, 32'h24);
		wr(5'h00, 8'h20);
		pulse;
		repeat (3) @(posedge clk);
		chk("irq", 1'h0, irq_v);
		chk("pend", 5'h00, pend);
		rd(5'h00, 32'h24);
		wr(5'h00, 8'h40);
		preq <= 1'h1;
		repeat (3) @(posedge clk);
		chk("irq", 1'h0, irq_v);
		wr(5'h00, 8'hC0);
		take(`VEC_HIGH);
		preq <= 1'h0;
		$display("test compatibility finished");
		wr(5'h0C, 8'h80);
		lag <= 4'h3;
		wr(5'h00, 8'h60);
		take(`VEC_LOW);
		rd(5'h00, 32'h24);
		wr(5'h04, 8'h04);
		wr(5'h00, 8'hA0);
		take(`VEC_HIGH);
		rd(5'h00, 32'h24);
		$display("test priority finished");
		print_verdict;
	end
endmodule // testbench
bind int_ctrl int_ctrl_assertions int_ctrl_assertions_i (.CLOCK(CLOCK), .RST(RST),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.PORT_PULLUP_LATCH(PORT_PULLUP_LATCH), .PORT_PULLUP_ON(PORT_PULLUP_ON),
	.IRQ_VALID(IRQ_VALID), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACCEPT(IRQ_ACCEPT),
	.PERIPH_REQ(PERIPH_REQ), .PENDING(PENDING));
`default_nettype wire
